// ==== tdcmc_pkg.sv ====
package tdcmc_pkg;
  // register map, word addressed by index, byte address = 4 * index
  localparam logic [3:0] ADDR_CFG0    = 4'h0;
  localparam logic [3:0] ADDR_CFG1    = 4'h1;
  localparam logic [3:0] ADDR_CFG6    = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_CFG0_RB = 4'h4;
  localparam logic [3:0] ADDR_CFG1_RB = 4'h5;

  localparam logic [31:0] CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST = 32'h5540_0000;
  localparam logic [31:0] CFG6_RST = 32'h0000_0000;

  // register 0 fields
  localparam int R0_SETTLE_LO   = 18;
  localparam int R0_PORT_CNT    = 17;
  localparam int R0_CYCLE_TIME  = 16;
  localparam int R0_DUMMY_CNT   = 15;
  localparam int R0_CLK_SEL     = 14;
  localparam int R0_CALIBRATE   = 13;
  localparam int R0_NO_AUTOCAL  = 12;
  localparam int R0_MODE_TWO    = 11;
  localparam int R0_STOP_B_INV  = 10;
  localparam int R0_STOP_A_INV  = 9;
  localparam int R0_START_INV   = 8;
  // register 1 fields
  localparam int R1_OPB_LO      = 28;
  localparam int R1_OPA_LO      = 24;
  localparam int R1_FAST_INIT   = 23;
  localparam int R1_HITS_B_LO   = 19;
  localparam int R1_HITS_A_LO   = 16;
  localparam int R1_FIRE_START  = 14;
  localparam int R1_SEN_MUX_LO  = 11;
  localparam int R1_FIN_MUX_LO  = 8;
  // register 6 field: top bit of settle delay
  localparam int R6_SETTLE_TOP  = 20;

  // timing at 20 MHz
  localparam int CLK_MHZ        = 20;
  localparam int SETTLE_480_US  = 480;
  localparam int SETTLE_1460_US = 1460;
  localparam int SETTLE_2440_US = 2440;
  localparam int SETTLE_5140_US = 5140;
  localparam int TCYC_SHORT_US  = 128;
  localparam int TCYC_LONG_US   = 512;
  localparam int HS_CYCLE_DIV   = 128;
  localparam int TCYC_SHORT_CYC = TCYC_SHORT_US * CLK_MHZ;
  localparam int TCYC_LONG_CYC  = TCYC_LONG_US * CLK_MHZ;
  localparam int DUMMY_SHORT    = 2;
  localparam int DUMMY_LONG     = 7;
  localparam logic [2:0] MAX_HITS = 3'h4;
  localparam logic [3:0] OP_NONE  = 4'h5;

  typedef enum logic [1:0] {
    TDCMC_IDLE   = 2'b00,
    TDCMC_SETTLE = 2'b01,
    TDCMC_DUMMY  = 2'b11,
    TDCMC_MEAS   = 2'b10
  } tdcmc_state_t;
endpackage

// ==== tdcmc_top.sv ====
`timescale 1ns/1ps
module tdcmc_top
  import tdcmc_pkg::*;
#(
  parameter int SETTLE_480_CYC  = SETTLE_480_US * CLK_MHZ,
  parameter int SETTLE_1460_CYC = SETTLE_1460_US * CLK_MHZ,
  parameter int SETTLE_2440_CYC = SETTLE_2440_US * CLK_MHZ,
  parameter int SETTLE_5140_CYC = SETTLE_5140_US * CLK_MHZ,
  parameter int TCYC_LONG_P     = TCYC_LONG_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        meas_start,
  input  wire logic        meas_done,
  input  wire logic        start_in,
  input  wire logic        stop_a_in,
  input  wire logic        stop_b_in,
  input  wire logic        fire_pulse,
  input  wire logic        clk_32k_tick,
  input  wire logic        clk_4k,
  input  wire logic        clk_32k,
  input  wire logic        comparator_out,
  input  wire logic        stop_enable_delayed,
  input  wire logic        direction_upstream,
  input  wire logic        temp_start,
  input  wire logic        temp_stop,
  input  wire logic        start_enable_pin_i,
  input  wire logic        fire_input_pin_i,
  output logic             start_enable_pin_o,
  output logic             start_enable_pin_oe_n,
  output logic             fire_input_pin_o,
  output logic             fire_input_pin_oe_n,
  output logic             converter_start_signal,
  output logic             stop_a_edge,
  output logic             stop_b_edge,
  output logic             start_enabled,
  output logic             fire_input_int,
  output logic             osc_settled,
  output logic             temp_cycle_tick,
  output logic             temp_dummy_phase,
  output logic [1:0]       temp_port_index,
  output logic             calibrated_results,
  output logic             autocal_request,
  output logic             mode_two_select,
  output logic             fast_init_enable,
  output logic [3:0]       alu_operand_a,
  output logic [3:0]       alu_operand_b,
  output logic             alu_b_minus_a,
  output logic [2:0]       expected_hits_a,
  output logic [2:0]       expected_hits_b
);
  import tdcmc_pkg::*;

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] clamp_hits(input logic [2:0] h);
    return (h > MAX_HITS) ? MAX_HITS : h;
  endfunction

  // shadow registers written by software, active copies latched at start
  logic [31:0] cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt, cfg6_r, cfg6_nxt;
  logic [31:0] act0_r, act0_nxt, act1_r, act1_nxt, act6_r, act6_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        status_bad_r, status_bad_nxt;

  tdcmc_state_t state_r, state_nxt;
  logic [17:0]  cnt_r, cnt_nxt;
  logic [2:0]   dummy_r, dummy_nxt;
  logic [1:0]   port_r, port_nxt;
  logic [6:0]   hsdiv_r, hsdiv_nxt;
  logic         settled_r, settled_nxt;
  logic         tick_r, tick_nxt;
  logic         autocal_r, autocal_nxt;
  logic         sa_d_r, sb_d_r, st_d_r;

  logic        wr_hit, cycle_src, cyc_done;
  logic [2:0]  settle_code;
  logic [17:0] settle_len, cyc_len;
  logic [2:0]  dummy_len;
  logic        start_pol, stop_a_pol, stop_b_pol;

  // bus answers reads one cycle after the request, writes at once
  assign wr_hit = avs_write;
  assign avs_waitrequest = avs_read & ~rvalid_r;

  always_comb begin
    cfg0_nxt = cfg0_r;
    cfg1_nxt = cfg1_r;
    cfg6_nxt = cfg6_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    status_bad_nxt = status_bad_r;
    if (wr_hit) begin
      if (avs_address == ADDR_CFG0) begin
        cfg0_nxt = merge_be(cfg0_r, avs_writedata, avs_byteenable);
      end else if (avs_address == ADDR_CFG1) begin
        cfg1_nxt = merge_be(cfg1_r, avs_writedata, avs_byteenable);
        // out-of-range hit counts flagged, clamped on use
        status_bad_nxt = (avs_writedata[R1_HITS_A_LO +: 3] > MAX_HITS) |
                         (avs_writedata[R1_HITS_B_LO +: 3] > MAX_HITS);
      end else if (avs_address == ADDR_CFG6) begin
        cfg6_nxt = merge_be(cfg6_r, avs_writedata, avs_byteenable);
      end
    end
    if (avs_read && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      if (avs_address == ADDR_CFG0_RB) begin
        rdata_nxt = cfg0_r;
      end else if (avs_address == ADDR_CFG1_RB) begin
        rdata_nxt = cfg1_r;
      end else if (avs_address == ADDR_CFG6) begin
        rdata_nxt = cfg6_r;
      end else if (avs_address == ADDR_STATUS) begin
        rdata_nxt = {25'h0, status_bad_r, autocal_r, port_r, settled_r, state_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  // latch active settings only at measurement start
  always_comb begin
    act0_nxt = act0_r;
    act1_nxt = act1_r;
    act6_nxt = act6_r;
    if (meas_start && state_r == TDCMC_IDLE) begin
      act0_nxt = cfg0_r;
      act1_nxt = cfg1_r;
      act6_nxt = cfg6_r;
    end
  end

  always_comb begin
    // two low bits here, top bit lives in the other register
    settle_code = {act6_r[R6_SETTLE_TOP], act0_r[R0_SETTLE_LO +: 2]};
    if (settle_code == 3'h2) begin
      settle_len = 18'(SETTLE_480_CYC);
    end else if (settle_code == 3'h3) begin
      settle_len = 18'(SETTLE_1460_CYC);
    end else if (settle_code == 3'h4) begin
      settle_len = 18'(SETTLE_2440_CYC);
    end else if (settle_code >= 3'h5) begin
      settle_len = 18'(SETTLE_5140_CYC);
    end else begin
      settle_len = 18'h0_0001;
    end
    cyc_len = act0_r[R0_CYCLE_TIME] ? 18'(TCYC_LONG_P) : 18'(TCYC_SHORT_CYC);
    dummy_len = act0_r[R0_DUMMY_CNT] ? 3'(DUMMY_LONG) : 3'(DUMMY_SHORT);
  end

  // cycle source: 32k tick or 128 fast periods
  assign cycle_src = act0_r[R0_CLK_SEL] ? (hsdiv_r == 7'h7f) : clk_32k_tick;
  assign cyc_done = (cnt_r >= cyc_len - 18'h0_0001) & cycle_src;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dummy_nxt = dummy_r;
    port_nxt = port_r;
    hsdiv_nxt = 7'(hsdiv_r + 7'h01);
    settled_nxt = settled_r;
    tick_nxt = 1'b0;
    autocal_nxt = 1'b0;
    case (state_r)
      TDCMC_IDLE: begin
        cnt_nxt = '0;
        if (meas_start) begin
          state_nxt = TDCMC_SETTLE;
          settled_nxt = 1'b0;
        end
      end
      TDCMC_SETTLE: begin
        cnt_nxt = 18'(cnt_r + 18'h0_0001);
        if (cnt_r + 18'h0_0001 >= settle_len) begin
          settled_nxt = 1'b1;
          cnt_nxt = '0;
          dummy_nxt = '0;
          state_nxt = TDCMC_DUMMY;
        end
      end
      TDCMC_DUMMY: begin
        cnt_nxt = 18'(cnt_r + 18'h0_0001);
        if (cyc_done) begin
          tick_nxt = 1'b1;
          cnt_nxt = '0;
          dummy_nxt = 3'(dummy_r + 3'h1);
          if (dummy_r + 3'h1 >= dummy_len) begin
            port_nxt = '0;
            state_nxt = TDCMC_MEAS;
          end
        end
      end
      TDCMC_MEAS: begin
        cnt_nxt = 18'(cnt_r + 18'h0_0001);
        if (cyc_done) begin
          tick_nxt = 1'b1;
          cnt_nxt = '0;
          port_nxt = 2'(port_r + 2'h1);
          // two or four ports
          if (port_r == (act0_r[R0_PORT_CNT] ? 2'h3 : 2'h1)) begin
            port_nxt = '0;
          end
        end
        if (meas_done) begin
          state_nxt = TDCMC_IDLE;
          autocal_nxt = ~act0_r[R0_NO_AUTOCAL];
        end
      end
      default: begin
        state_nxt = TDCMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_r <= CFG0_RST;
      cfg1_r <= CFG1_RST;
      cfg6_r <= CFG6_RST;
      act0_r <= CFG0_RST;
      act1_r <= CFG1_RST;
      act6_r <= CFG6_RST;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      status_bad_r <= 1'b0;
      state_r <= TDCMC_IDLE;
      cnt_r <= '0;
      dummy_r <= '0;
      port_r <= '0;
      hsdiv_r <= '0;
      settled_r <= 1'b0;
      tick_r <= 1'b0;
      autocal_r <= 1'b0;
      sa_d_r <= 1'b0;
      sb_d_r <= 1'b0;
      st_d_r <= 1'b0;
    end else begin
      cfg0_r <= cfg0_nxt;
      cfg1_r <= cfg1_nxt;
      cfg6_r <= cfg6_nxt;
      act0_r <= act0_nxt;
      act1_r <= act1_nxt;
      act6_r <= act6_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      status_bad_r <= status_bad_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dummy_r <= dummy_nxt;
      port_r <= port_nxt;
      hsdiv_r <= hsdiv_nxt;
      settled_r <= settled_nxt;
      tick_r <= tick_nxt;
      autocal_r <= autocal_nxt;
      sa_d_r <= stop_a_pol;
      sb_d_r <= stop_b_pol;
      st_d_r <= start_pol;
    end
  end

  assign avs_readdata = rdata_r;
  assign osc_settled = settled_r;
  assign temp_cycle_tick = tick_r;
  assign temp_dummy_phase = (state_r == TDCMC_DUMMY);
  assign temp_port_index = port_r;
  assign autocal_request = autocal_r;

  // polarity: inverted input makes the falling edge active
  assign start_pol  = start_in ^ act0_r[R0_START_INV];
  assign stop_a_pol = stop_a_in ^ act0_r[R0_STOP_A_INV];
  assign stop_b_pol = stop_b_in ^ act0_r[R0_STOP_B_INV];
  assign stop_a_edge = stop_a_pol & ~sa_d_r & (expected_hits_a != 3'h0);
  assign stop_b_edge = stop_b_pol & ~sb_d_r & (expected_hits_b != 3'h0);

  // start-enable pin: any nonzero code forces enable high
  logic [2:0] sen_code, fin_code;
  assign sen_code = act1_r[R1_SEN_MUX_LO +: 3];
  assign fin_code = act1_r[R1_FIN_MUX_LO +: 3];
  assign start_enabled = (sen_code != 3'h0) ? 1'b1 : start_enable_pin_i;
  assign fire_input_int = (fin_code > 3'h1) ? 1'b0 : fire_input_pin_i;

  // fire pulse replaces the external start when selected
  assign converter_start_signal = act1_r[R1_FIRE_START] ? fire_pulse :
                                  (start_pol & ~st_d_r & start_enabled);

  always_comb begin
    start_enable_pin_oe_n = (sen_code == 3'h0);
    case (sen_code)
      3'h1: start_enable_pin_o = converter_start_signal;
      3'h2: start_enable_pin_o = stop_a_pol;
      3'h3: start_enable_pin_o = stop_b_pol;
      3'h4: start_enable_pin_o = temp_stop;
      3'h5: start_enable_pin_o = direction_upstream;
      3'h7: start_enable_pin_o = clk_4k;
      default: start_enable_pin_o = 1'b0;
    endcase
    fire_input_pin_oe_n = (fin_code == 3'h0);
    case (fin_code)
      3'h1: fire_input_pin_o = converter_start_signal;
      3'h2: fire_input_pin_o = stop_a_pol;
      3'h3: fire_input_pin_o = stop_b_pol;
      3'h4: fire_input_pin_o = temp_start;
      3'h5: fire_input_pin_o = stop_enable_delayed;
      3'h6: fire_input_pin_o = comparator_out;
      3'h7: fire_input_pin_o = clk_32k;
      default: fire_input_pin_o = 1'b0;
    endcase
  end

  // uncalibrated only honoured in mode one
  assign mode_two_select = act0_r[R0_MODE_TWO];
  assign calibrated_results = act0_r[R0_CALIBRATE] | mode_two_select;
  assign fast_init_enable = act1_r[R1_FAST_INIT];
  // operand codes passed to the ALU; code 5 in mode one means no action
  assign alu_operand_a = act1_r[R1_OPA_LO +: 4];
  assign alu_operand_b = act1_r[R1_OPB_LO +: 4];
  assign alu_b_minus_a = mode_two_select;
  assign expected_hits_a = clamp_hits(act1_r[R1_HITS_A_LO +: 3]);
  assign expected_hits_b = clamp_hits(act1_r[R1_HITS_B_LO +: 3]);
endmodule

// ==== tdcmc_checker.sv ====
`timescale 1ns/1ps
module tdcmc_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       meas_start,
  input wire logic       meas_done,
  input wire logic       start_enable_pin_oe_n,
  input wire logic       start_enabled,
  input wire logic       fire_input_pin_i,
  input wire logic       fire_input_pin_oe_n,
  input wire logic       fire_input_int,
  input wire logic       stop_a_edge,
  input wire logic       osc_settled,
  input wire logic       temp_dummy_phase,
  input wire logic       calibrated_results,
  input wire logic       autocal_request,
  input wire logic       mode_two_select,
  input wire logic       alu_b_minus_a,
  input wire logic [3:0] alu_operand_a,
  input wire logic [2:0] expected_hits_a,
  input wire logic [2:0] expected_hits_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_wait: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
  a_write_nowait: assert property (
    avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_settle_first: assert property (
    temp_dummy_phase |-> osc_settled) else $error("dummy before settle");
  a_enable_forced: assert property (
    !start_enable_pin_oe_n |-> start_enabled) else $error("start enable not forced");
  a_fire_pass: assert property (
    fire_input_pin_oe_n |-> fire_input_int == fire_input_pin_i) else $error("fire input lost");
  a_order_mode: assert property (
    alu_b_minus_a == mode_two_select) else $error("operand order wrong");
  a_cal_mode_two: assert property (
    mode_two_select |-> calibrated_results) else $error("uncalibrated in mode two");
  a_hits_bound: assert property (
    expected_hits_a <= 3'h4 && expected_hits_b <= 3'h4) else $error("hit count above four");
  a_stop_enabled: assert property (
    stop_a_edge |-> expected_hits_a != 3'h0) else $error("stop on disabled channel");
  a_autocal_cause: assert property (
    autocal_request |-> $past(meas_done)) else $error("autocal without done");
  a_cfg_hold: assert property (
    !$past(meas_start) |-> $stable(mode_two_select) && $stable(alu_operand_a))
    else $error("config changed mid run");
endmodule
bind tdcmc_top tdcmc_checker i_tdcmc_checker (.clk, .rst_n, .avs_read, .avs_write,
  .avs_waitrequest, .meas_start, .meas_done, .start_enable_pin_oe_n, .start_enabled,
  .fire_input_pin_i, .fire_input_pin_oe_n, .fire_input_int, .stop_a_edge, .osc_settled,
  .temp_dummy_phase, .calibrated_results, .autocal_request, .mode_two_select,
  .alu_b_minus_a, .alu_operand_a, .expected_hits_a, .expected_hits_b);

// ==== tdcmc_partner.sv ====
`timescale 1ns/1ps
module tdcmc_partner #(
  parameter int P32 = 610
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic go,
  output logic      start_in,
  output logic      stop_a_in,
  output logic      stop_b_in,
  output logic      fire_pulse,
  output logic      clk_32k_tick,
  output logic      clk_32k,
  output logic      clk_4k,
  output logic      comparator_out
);
  int unsigned t_r;
  int unsigned ph_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_r  <= 0;
      ph_r <= 99;
    end else begin
      t_r  <= t_r + 1;
      ph_r <= go ? 0 : (ph_r < 99 ? ph_r + 1 : ph_r);
    end
  end
  // fire leads start, so a start input wrongly honoured shows last
  assign fire_pulse     = (ph_r == 2);
  assign start_in       = (ph_r >= 5) && (ph_r < 15);
  assign stop_a_in      = (ph_r >= 8) && (ph_r < 18);
  assign stop_b_in      = (ph_r >= 10) && (ph_r < 20);
  assign clk_32k_tick   = (t_r % P32) == P32 - 1;
  assign clk_32k        = (t_r % P32) >= P32 / 2;
  assign clk_4k         = (t_r % (8 * P32)) >= 4 * P32;
  assign comparator_out = t_r[2];
endmodule

// ==== test_tdc_measurement_config.sv ====
`timescale 1ns/1ps
module test_tdc_measurement_config;
  import tdcmc_pkg::*;
  localparam int P32 = 610;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, meas_start, meas_done, go;
  logic [3:0] avs_address, avs_byteenable, alu_operand_a, alu_operand_b, sen_src, fin_src;
  logic [31:0] avs_writedata, avs_readdata, rd, c0, c1;
  logic start_in, stop_a_in, stop_b_in, fire_pulse, clk_32k_tick, clk_4k, clk_32k;
  logic comparator_out, stop_enable_delayed, direction_upstream, temp_start, temp_stop;
  logic start_enable_pin_i, fire_input_pin_i, start_enable_pin_o, start_enable_pin_oe_n;
  logic fire_input_pin_o, fire_input_pin_oe_n, converter_start_signal, stop_a_edge;
  logic stop_b_edge, start_enabled, fire_input_int, osc_settled, temp_cycle_tick;
  logic temp_dummy_phase, calibrated_results, autocal_request, mode_two_select;
  logic fast_init_enable, alu_b_minus_a, sa_lvl, cs_fire;
  logic [1:0] temp_port_index;
  logic [2:0] expected_hits_a, expected_hits_b;
  int bad_count, compares, n_settle, n_tick, gap, last_gap, n_auto, i;
  // each row: configuration word 0, configuration word 1; mux codes follow the row index
  logic [63:0] rows [8] = '{64'h0009_6000_2101_0000, 64'h000B_D2A1_C994_4911,
    64'h0009_4C02_311A_1222, 64'h000B_FA03_41A3_1B33, 64'h0009_2104_763D_6444,
    64'h0009_7255_5009_2D55, 64'h0009_E806_2182_7666, 64'h0009_42FF_101B_3F77};
  int st_lo [6] = '{2, 3, 0, 1, 2, 0};
  int st_top [6] = '{0, 0, 1, 1, 1, 0};
  int st_exp [6] = '{10, 20, 30, 40, 40, 1};
  tdcmc_top #(.SETTLE_480_CYC(10), .SETTLE_1460_CYC(20), .SETTLE_2440_CYC(30),
    .SETTLE_5140_CYC(40), .TCYC_LONG_P(20)) i_tdcmc_top (.clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .meas_start, .meas_done, .start_in, .stop_a_in, .stop_b_in, .fire_pulse, .clk_32k_tick,
    .clk_4k, .clk_32k, .comparator_out, .stop_enable_delayed, .direction_upstream,
    .temp_start, .temp_stop, .start_enable_pin_i, .fire_input_pin_i, .start_enable_pin_o,
    .start_enable_pin_oe_n, .fire_input_pin_o, .fire_input_pin_oe_n, .converter_start_signal,
    .stop_a_edge, .stop_b_edge, .start_enabled, .fire_input_int, .osc_settled,
    .temp_cycle_tick, .temp_dummy_phase, .temp_port_index, .calibrated_results,
    .autocal_request, .mode_two_select, .fast_init_enable, .alu_operand_a, .alu_operand_b,
    .alu_b_minus_a, .expected_hits_a, .expected_hits_b);
  tdcmc_partner #(.P32(P32)) i_tdcmc_partner (.clk, .rst_n, .go, .start_in, .stop_a_in,
    .stop_b_in, .fire_pulse, .clk_32k_tick, .clk_32k, .clk_4k, .comparator_out);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (stop_a_edge === 1'b1) sa_lvl <= stop_a_in;
    if (converter_start_signal === 1'b1) cs_fire <= fire_pulse;
  end
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      close_out();
    end
    @(posedge clk);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v) begin
      @(posedge clk);
      n++;
      if (n > 9000) begin
        bad_count++;
        close_out();
      end
    end
  endtask
  task automatic cfg(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    bus(1'b1, ADDR_CFG0, a);
    bus(1'b1, ADDR_CFG1, b);
    bus(1'b1, ADDR_CFG6, c);
  endtask
  task automatic go_meas();
    int k;
    sa_lvl = 1'bx;
    cs_fire = 1'bx;
    meas_start <= 1'b1;
    @(posedge clk);
    meas_start <= 1'b0;
    @(posedge clk);
    wait_lvl(osc_settled, 1'b1, n_settle);
    wait_lvl(temp_dummy_phase, 1'b1, k);
    n_tick = 0;
    gap = 0;
    while (temp_dummy_phase === 1'b1) begin
      @(posedge clk);
      gap++;
      if (temp_cycle_tick === 1'b1) begin
        n_tick++;
        last_gap = gap;
        gap = 0;
      end
      if (gap > 9000) begin
        bad_count++;
        close_out();
      end
    end
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (25) @(posedge clk);
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    n_auto = 0;
    repeat (3) begin
      @(posedge clk);
      if (autocal_request === 1'b1) n_auto++;
    end
  endtask
  function automatic logic [2:0] hclamp(input logic [2:0] h);
    return (h > MAX_HITS) ? MAX_HITS : h;
  endfunction
  initial begin
    {avs_read, avs_write, meas_start, meas_done, go, rst_n} = '0;
    {direction_upstream, temp_start, stop_enable_delayed, temp_stop} = 4'b1100;
    {start_enable_pin_i, fire_input_pin_i} = 2'b11;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      c0 = rows[i][63:32];
      c1 = rows[i][31:0];
      cfg(c0, c1, 32'h0000_0000);
      if (i > 0) chk("hold_mode", mode_two_select, rows[i-1][43]);
      if (i > 0) chk("hold_op", alu_operand_a, rows[i-1][27:24]);
      go_meas();
      @(posedge clk);
      start_enable_pin_i <= 1'b0;
      @(negedge clk);
      sen_src = {clk_4k, 1'b0, direction_upstream, temp_stop};
      fin_src = {clk_32k, comparator_out, stop_enable_delayed, temp_start};
      chk("mode_two", mode_two_select, c0[R0_MODE_TWO]);
      chk("b_minus_a", alu_b_minus_a, c0[R0_MODE_TWO]);
      chk("calibrated", calibrated_results, c0[R0_CALIBRATE] | c0[R0_MODE_TWO]);
      chk("fast_init", fast_init_enable, c1[R1_FAST_INIT]);
      chk("op_a", alu_operand_a, c1[R1_OPA_LO +: 4]);
      chk("op_b", alu_operand_b, c1[R1_OPB_LO +: 4]);
      chk("hits_a", expected_hits_a, hclamp(c1[R1_HITS_A_LO +: 3]));
      chk("hits_b", expected_hits_b, hclamp(c1[R1_HITS_B_LO +: 3]));
      chk("autocal", n_auto, !c0[R0_NO_AUTOCAL]);
      chk("dummy", n_tick, c0[R0_DUMMY_CNT] ? DUMMY_LONG : DUMMY_SHORT);
      chk("tick_gap", last_gap, c0[R0_CLK_SEL] ? HS_CYCLE_DIV : P32);
      chk("stop_pol", sa_lvl, !c0[R0_STOP_A_INV]);
      chk("start_src", cs_fire, c1[R1_FIRE_START]);
      chk("sen_oe_n", start_enable_pin_oe_n, i == 0);
      chk("start_en", start_enabled, i != 0);
      chk("fin_oe_n", fire_input_pin_oe_n, i == 0);
      if (i != 1) chk("fin_int", fire_input_int, i == 0);
      if (i >= 4 && i != 6) chk("sen_o", start_enable_pin_o, sen_src[i-4]);
      if (i >= 4) chk("fin_o", fire_input_pin_o, fin_src[i-4]);
      @(posedge clk);
      start_enable_pin_i <= 1'b1;
      bus(1'b0, ADDR_CFG0_RB, '0);
      chk("rb0", rd, c0);
      bus(1'b0, ADDR_CFG1_RB, '0);
      chk("rb1", rd, c1);
    end
    for (i = 0; i < 6; i++) begin
      cfg(32'h0001_6000 | (32'(st_lo[i]) << R0_SETTLE_LO), 32'h2101_0000,
        32'(st_top[i]) << R6_SETTLE_TOP);
      go_meas();
      chk("settle", n_settle + 3 >= st_exp[i] && n_settle <= st_exp[i] + 3, 1);
    end
    bus(1'b0, ADDR_CFG0, '0);
    chk("wo_read", rd, 32'h0000_0000);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    bus(1'b0, 4'hF, '0);
    chk("unmapped", rd, 32'h0000_0000);
    meas_start <= 1'b1;
    @(posedge clk);
    meas_start <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("rst_mode", mode_two_select, 1'b0);
    bus(1'b0, ADDR_CFG0_RB, '0);
    chk("rst_cfg0", rd, 32'h0000_0000);
    avs_byteenable <= 4'h1;
    bus(1'b1, ADDR_CFG1, 32'hFFFF_FFFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, ADDR_CFG1_RB, '0);
    chk("rst_cfg1_tag", rd, 32'h5540_00FF);
    close_out();
  end
endmodule
